// ### include/masked_irq_status_pkg.sv
// package for the masked interrupt status block: offsets, bit positions, reset values
// assumes an apb slave with 32-bit data and byte addresses
package masked_irq_status_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_RAW_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASKED_IRQ_STATUS = 8'h34;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h38;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h3c;
  localparam logic [7:0] OFF_TX_THRESHOLD_REG = 8'h40;
  localparam logic [7:0] OFF_RX_THRESHOLD_REG = 8'h44;
  localparam logic [7:0] OFF_FIFO_LEVEL = 8'h48;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_TX_EMPTY = 0;
  localparam int BIT_TX_LOW = 1;
  localparam int BIT_TX_FULL = 2;
  localparam int BIT_TX_OVERRUN = 3;
  localparam int BIT_RX_EMPTY = 4;
  localparam int BIT_RX_HIGH = 5;
  localparam int BIT_RX_FULL = 6;
  localparam int BIT_TGT_READ_REQ = 16;
  localparam int BIT_TGT_READ_UNDERFLOW = 17;
  localparam int BIT_TGT_WRITE_REQ = 18;
  localparam int BIT_CTRL_DONE = 19;
  localparam int BIT_TGT_DONE = 20;
  // defined bits; 15:7 and 23:21 and above stay zero
  localparam logic [31:0] DEFINED_MASK = 32'h001f_007f;
  // sticky bits, cleared by writing one to the clear register
  localparam logic [31:0] STICKY_MASK = 32'h0018_0008;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic tgt_read_req;
    logic tgt_read_busy;
    logic tgt_write_req;
    logic ctrl_done;
    logic tgt_done;
  } core_events_s;
endpackage : masked_irq_status_pkg

// ### hw/i2c_masked_irq_status.sv
// masked interrupt status logic of a two-wire controller/target, apb slave
// assumes core events from the same clock domain, except the serial clock
// line and the target read/write request levels, which arrive from pins
// How it works
// - masked status at 0x34, read-only, reset zero
// - bit 0: transmit fifo empty
// - bit 1: transmit count at or below threshold
// - bit 2: transmit fifo full
// - bit 3: transmit overrun, write while full
// - bit 4: receive fifo empty
// - bit 5: receive count at or above threshold
// - bit 6: receive fifo full
// - bit 16: target read request pending
// - bit 17: fifo empty during target read
// - bit 18: target write request pending
// - bit 19: controller transaction done, awaiting acknowledge
// - bit 20: target transaction done, awaiting acknowledge
// - reserved bits read zero
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module i2c_masked_irq_status #(
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [8:0] core_ev,
  input wire logic scl_pin,
  input wire logic tgt_read_req_pin,
  input wire logic tgt_write_req_pin,
  output logic irq
);
  // ****************************************
  // elaboration checks
  // ****************************************
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255 || (1 << CNT_W) <= FIFO_DEPTH) begin : g_chk
    $error("fifo depth does not fit the count width");
  end

  localparam logic [CNT_W-1:0] DEPTH = CNT_W'(FIFO_DEPTH);

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic up,
                                            input logic dn);
    logic [CNT_W-1:0] r;
    r = c;
    if (up && !dn) begin
      r = c + CNT_W'(1);
    end else if (dn && !up) begin
      r = c - CNT_W'(1);
    end
    return r;
  endfunction : step

  masked_irq_status_pkg::core_events_s ev;
  assign ev = masked_irq_status_pkg::core_events_s'(core_ev);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // scl is only sampled for visibility; target request levels come from pads
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else if (clk_en) begin
      sync1 <= {scl_pin, tgt_write_req_pin, tgt_read_req_pin};
      sync2 <= sync1;
    end
  end
  logic pin_read_req;
  logic pin_write_req;
  assign pin_read_req = sync2[0];
  assign pin_write_req = sync2[1];

  // ****************************************
  // fifo levels and thresholds
  // ****************************************
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  logic [7:0] tx_thr, next_tx_thr, rx_thr, next_rx_thr;
  logic [31:0] enable, next_enable, sticky, next_sticky;
  logic [31:0] prdata_q, next_prdata;
  logic irq_q, next_irq;
  logic tx_full, tx_ovr_ev;
  logic [31:0] raw, masked;
  logic wr_access, rd_access;

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign tx_full = (tx_cnt == DEPTH);
  assign tx_ovr_ev = ev.tx_push && tx_full && !ev.tx_pop;

  always_comb begin
    next_tx_cnt = tx_cnt;
    next_rx_cnt = rx_cnt;
    if (!tx_ovr_ev) begin
      next_tx_cnt = step(tx_cnt, ev.tx_push, ev.tx_pop && tx_cnt != '0);
    end
    next_rx_cnt = step(rx_cnt, ev.rx_push && rx_cnt != DEPTH, ev.rx_pop && rx_cnt != '0);
    next_tx_thr = tx_thr;
    next_rx_thr = rx_thr;
    next_enable = enable;
    if (wr_access && paddr == masked_irq_status_pkg::OFF_TX_THRESHOLD_REG) begin
      next_tx_thr = pwdata[7:0];
    end
    if (wr_access && paddr == masked_irq_status_pkg::OFF_RX_THRESHOLD_REG) begin
      next_rx_thr = pwdata[7:0];
    end
    if (wr_access && paddr == masked_irq_status_pkg::OFF_IRQ_ENABLE) begin
      next_enable = pwdata & masked_irq_status_pkg::DEFINED_MASK;
    end
  end

  // ****************************************
  // sticky events: set wins over clear
  // ****************************************
  always_comb begin
    logic [31:0] set_v;
    set_v = '0;
    set_v[masked_irq_status_pkg::BIT_TX_OVERRUN] = tx_ovr_ev;
    set_v[masked_irq_status_pkg::BIT_CTRL_DONE] = ev.ctrl_done;
    set_v[masked_irq_status_pkg::BIT_TGT_DONE] = ev.tgt_done;
    next_sticky = sticky;
    if (wr_access && paddr == masked_irq_status_pkg::OFF_IRQ_CLEAR) begin
      next_sticky = sticky & ~(pwdata & masked_irq_status_pkg::STICKY_MASK);
    end
    next_sticky = next_sticky | set_v;
  end

  // ****************************************
  // raw and masked status
  // ****************************************
  always_comb begin
    raw = '0;
    raw[masked_irq_status_pkg::BIT_TX_EMPTY] = (tx_cnt == '0);
    raw[masked_irq_status_pkg::BIT_TX_LOW] = ({{(8 > CNT_W ? 8 - CNT_W : 0){1'b0}}, tx_cnt} <= tx_thr);
    raw[masked_irq_status_pkg::BIT_TX_FULL] = tx_full;
    raw[masked_irq_status_pkg::BIT_TX_OVERRUN] = sticky[masked_irq_status_pkg::BIT_TX_OVERRUN];
    raw[masked_irq_status_pkg::BIT_RX_EMPTY] = (rx_cnt == '0);
    raw[masked_irq_status_pkg::BIT_RX_HIGH] = ({{(8 > CNT_W ? 8 - CNT_W : 0){1'b0}}, rx_cnt} >= rx_thr);
    raw[masked_irq_status_pkg::BIT_RX_FULL] = (rx_cnt == DEPTH);
    raw[masked_irq_status_pkg::BIT_TGT_READ_REQ] = pin_read_req || ev.tgt_read_req;
    raw[masked_irq_status_pkg::BIT_TGT_READ_UNDERFLOW] = ev.tgt_read_busy && tx_cnt == '0;
    raw[masked_irq_status_pkg::BIT_TGT_WRITE_REQ] = pin_write_req || ev.tgt_write_req;
    raw[masked_irq_status_pkg::BIT_CTRL_DONE] = sticky[masked_irq_status_pkg::BIT_CTRL_DONE];
    raw[masked_irq_status_pkg::BIT_TGT_DONE] = sticky[masked_irq_status_pkg::BIT_TGT_DONE];
    masked = raw & enable & masked_irq_status_pkg::DEFINED_MASK;
  end

  // ****************************************
  // apb read mux, zero-wait answer
  // ****************************************
  always_comb begin
    next_prdata = prdata_q;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        masked_irq_status_pkg::OFF_MASKED_IRQ_STATUS: next_prdata = masked;
        masked_irq_status_pkg::OFF_RAW_STATUS: next_prdata = raw;
        masked_irq_status_pkg::OFF_IRQ_ENABLE: next_prdata = enable;
        masked_irq_status_pkg::OFF_TX_THRESHOLD_REG: next_prdata = {24'h000000, tx_thr};
        masked_irq_status_pkg::OFF_RX_THRESHOLD_REG: next_prdata = {24'h000000, rx_thr};
        masked_irq_status_pkg::OFF_FIFO_LEVEL: next_prdata = {8'h00, sync2[2], 7'h00,
                                                 8'(rx_cnt), 8'(tx_cnt)};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_irq = |masked;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= '0;
      rx_cnt <= '0;
      tx_thr <= masked_irq_status_pkg::RST_THRESHOLD;
      rx_thr <= masked_irq_status_pkg::RST_THRESHOLD;
      enable <= masked_irq_status_pkg::RST_ENABLE;
      sticky <= masked_irq_status_pkg::RST_STATUS;
      prdata_q <= masked_irq_status_pkg::RST_STATUS;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      tx_thr <= next_tx_thr;
      rx_thr <= next_rx_thr;
      enable <= next_enable;
      sticky <= next_sticky;
      prdata_q <= next_prdata;
      irq_q <= next_irq;
    end
  end

  assign prdata = prdata_q;
  assign irq = irq_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // checks
  // ****************************************
  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (masked & ~masked_irq_status_pkg::DEFINED_MASK) == 32'h0) else $error("reserved bit set");
  AST_MASKED_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    (masked & ~enable) == 32'h0) else $error("disabled source shows");
  AST_TX_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    masked[0] == (tx_cnt == '0 && enable[0])) else $error("tx empty wrong");
  AST_TX_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[1] && 8'(tx_cnt) > tx_thr) |-> !masked[1]) else $error("tx low wrong");
  AST_TX_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    masked[2] |-> tx_cnt == DEPTH) else $error("tx full wrong");
  AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && tx_ovr_ev) |=> sticky[3]) else $error("overrun lost");
  AST_RX_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[5] && 8'(rx_cnt) >= rx_thr) |-> masked[5]) else $error("rx high wrong");
  AST_RX_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    masked[6] |-> rx_cnt == DEPTH) else $error("rx full wrong");
  AST_CTRL_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ev.ctrl_done) |=> sticky[19]) else $error("done lost");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && $rose(|masked)) |=> irq) else $error("irq late");

  // ****************************************
  // converse checks: live flags also clear when their cause goes away, sticky ones on a clear write
  // ****************************************
  // the live flags are checked both ways so a stuck-at bit cannot hide
  AST_RX_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    masked[4] == (rx_cnt == '0 && enable[4]))
    else $error("rx empty wrong");

  AST_TX_LOW_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[1] && 8'(tx_cnt) <= tx_thr) |-> masked[1])
    else $error("tx low missing");

  AST_TX_FULL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[2] && tx_cnt == DEPTH) |-> masked[2])
    else $error("tx full missing");

  AST_RX_HIGH_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (8'(rx_cnt) < rx_thr) |-> !masked[5])
    else $error("rx high stuck");

  AST_RX_FULL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[6] && rx_cnt == DEPTH) |-> masked[6])
    else $error("rx full missing");

  AST_READ_REQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[16] && pin_read_req) |-> masked[16])
    else $error("read request missing");

  AST_READ_REQ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (!pin_read_req && !ev.tgt_read_req) |-> !masked[16])
    else $error("read request stuck");

  AST_UFLOW_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    masked[17] |-> tx_cnt == '0)
    else $error("underflow with data");

  AST_UFLOW_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[17] && ev.tgt_read_busy && tx_cnt == '0) |-> masked[17])
    else $error("underflow missing");

  AST_WRITE_REQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (enable[18] && pin_write_req) |-> masked[18])
    else $error("write request missing");

  AST_WRITE_REQ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (!pin_write_req && !ev.tgt_write_req) |-> !masked[18])
    else $error("write request stuck");

  AST_TGT_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ev.tgt_done) |=> sticky[20])
    else $error("target done lost");

  AST_OVR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_access && paddr == masked_irq_status_pkg::OFF_IRQ_CLEAR && pwdata[3] && !tx_ovr_ev)
    |=> !sticky[3]) else $error("overrun not cleared");

  AST_CTRL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_access && paddr == masked_irq_status_pkg::OFF_IRQ_CLEAR && pwdata[19] && !ev.ctrl_done)
    |=> !sticky[19]) else $error("controller done not cleared");

  AST_TGT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_access && paddr == masked_irq_status_pkg::OFF_IRQ_CLEAR && pwdata[20] && !ev.tgt_done)
    |=> !sticky[20]) else $error("target done not cleared");

  AST_MASKED_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == masked_irq_status_pkg::OFF_MASKED_IRQ_STATUS)
    |=> prdata == $past(masked)) else $error("masked read wrong");

  AST_RO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && paddr == masked_irq_status_pkg::OFF_MASKED_IRQ_STATUS) |=> $stable(enable))
    else $error("write to read-only changed state");

  AST_IRQ_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && masked == 32'h0) |=> !irq)
    else $error("irq stuck");
endmodule : i2c_masked_irq_status

// ### dv/two_wire_partner.sv
// two-wire bus neighbours: serial clock and target request levels
// assumes the bench opens and closes frames by calling start and stop
`timescale 1ns/1ps
module two_wire_partner (
  output logic scl_pin,
  output logic rd_req,
  output logic wr_req
);
  logic active = 1'b0;
  initial begin
    scl_pin = 1'b1;
    rd_req = 1'b0;
    wr_req = 1'b0;
  end
  // clock idles high between frames, 125 ns period inside them
  always begin
    #62.5;
    scl_pin = active ? ~scl_pin : 1'b1;
  end
  task start(input logic rd, input logic wr);
    active = 1'b1;
    rd_req = rd;
    wr_req = wr;
  endtask : start
  task stop();
    active = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
  endtask : stop
endmodule : two_wire_partner

// ### dv/testbench.sv
// bench for the masked status block: apb master, event driver, reference model
// assumes the two-wire partner model and a 4-entry fifo build of the design
`timescale 1ns/1ps
module testbench;
  localparam int D = 4;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, r, en = 32'h0, seed = 32'd7414;
  logic pready, pslverr, irq, scl_pin, rd_pin, wr_pin;
  logic [8:0] core_ev = 9'h000;
  int miscompares = 0, checks = 0, tx = 0, rx = 0, tth = 0, rth = 0;
  bit ovr, cd, td, rdl, busy, wrl, rdp, wrp;
  always #2 pclk = ~pclk;
  i2c_masked_irq_status #(.FIFO_DEPTH(D), .CNT_W(3)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ev(core_ev),
    .scl_pin(scl_pin), .tgt_read_req_pin(rd_pin), .tgt_write_req_pin(wr_pin), .irq(irq));
  two_wire_partner partner (.scl_pin(scl_pin), .rd_req(rd_pin), .wr_req(wr_pin));
  // ****************************************
  // reference model and helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] raw();
    logic [31:0] v;
    v = 32'h0;
    v[0] = tx == 0;
    v[1] = tx <= tth;
    v[2] = tx == D;
    v[3] = ovr;
    v[4] = rx == 0;
    v[5] = rx >= rth;
    v[6] = rx == D;
    v[16] = rdl | rdp;
    v[17] = tx == 0 && busy;
    v[18] = wrl | wrp;
    v[19] = cd;
    v[20] = td;
    return v;
  endfunction : raw
  task results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task cmp(input string name, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask : cmp
  // request held from setup until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      results();
    end
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task ev(input int b);
    @(posedge pclk);
    core_ev <= {4'h0, rdl, busy, wrl, 2'b00} | (9'h001 << b);
    @(posedge pclk);
    core_ev <= {4'h0, rdl, busy, wrl, 2'b00};
  endtask : ev
  task check();
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h34, 32'h0);
    cmp("masked", raw() & en, q);
    apb(1'b0, 8'h30, 32'h0);
    cmp("raw", raw(), q);
    cmp("irq", {31'h0, |(raw() & en)}, {31'h0, irq});
    cmp("pslverr", 32'h0, {31'h0, pslverr});
    apb(1'b0, 8'h48, 32'h0);
    cmp("level", 32'(rx * 256 + tx), {16'h0, q[15:0]});
  endtask : check
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h34, 32'h0);
    cmp("reset", 32'h0, q);
    apb(1'b0, 8'h4c, 32'h0);
    cmp("unmapped", 32'h0, q);
    en = 32'h001f_007f;
    apb(1'b1, 8'h38, en);
    apb(1'b1, 8'h34, 32'hffff_ffff);
    check();
    for (int k = 0; k <= D; k++) begin
      ev(8);
      ev(6);
      if (tx == D) ovr = 1;
      else tx++;
      if (rx < D) rx++;
    end
    check();
    for (int i = 0; i < 120; i++) begin
      r = xs();
      {rdl, busy, wrl} = r[10:8];
      case (r[2:0])
        3'd0: begin ev(8); if (tx == D) ovr = 1; else tx++; end
        3'd1: if (tx > 0) begin ev(7); tx--; end
        3'd2: begin ev(6); if (rx < D) rx++; end
        3'd3: if (rx > 0) begin ev(5); rx--; end
        3'd4: begin
          tth = r[13:11] % 5;
          rth = r[16:14] % 5;
          apb(1'b1, 8'h40, 32'(tth));
          apb(1'b1, 8'h44, 32'(rth));
        end
        3'd5: begin en = r & 32'h001f_007f; apb(1'b1, 8'h38, en); end
        3'd6: begin ev(r[11] ? 1 : 0); if (r[11]) cd = 1; else td = 1; end
        default: begin apb(1'b1, 8'h3c, r); ovr &= ~r[3]; cd &= ~r[19]; td &= ~r[20]; end
      endcase
      ev(9);
      check();
    end
    en = 32'h001f_007f;
    apb(1'b1, 8'h38, en);
    {rdl, busy, wrl} = 3'b000;
    ev(9);
    partner.start(1'b1, 1'b0);
    rdp = 1;
    check();
    partner.start(1'b0, 1'b1);
    {rdp, wrp} = 2'b01;
    check();
    partner.stop();
    wrp = 0;
    check();
    clk_en <= 1'b0;
    ev(8);
    @(posedge pclk);
    clk_en <= 1'b1;
    check();
    results();
  end
endmodule : testbench
